/* include/fesr_pkg.sv */
// Constants, timing counts and state type for the erase suspend/reset controller
package fesr_pkg;
   // ==========================================
   // Geometry
   localparam int PRI_N = 8;
   localparam int SEC2_N = 4;
   localparam int SEC_N = PRI_N + SEC2_N;
   localparam int ADDR_W = 12;
   localparam int TMR_W = 14;

   // ==========================================
   // Command codes and unlock cycles
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_RESET_DFLT = 8'hf0;
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 12'haaa;
   localparam logic [7:0] UNLOCK1_DATA = 8'haa;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 12'h554;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;

   // ==========================================
   // Timing
   localparam int CLK_NS = 10;
   localparam int SUSP_MIN_NS = 100;
   localparam int SUSP_MAX_NS = 15000;
   localparam int SUSP_CYC = (SUSP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int ABORT_MAX_NS = 25000;
   localparam int ABORT_CYC = ABORT_MAX_NS / CLK_NS;
   localparam int ERASE_WIN_NS = 100000;
   localparam int ERASE_WIN_CYC = ERASE_WIN_NS / CLK_NS;

   // ==========================================
   // Controller states
   typedef enum logic [2:0] {
      ST_READ,
      ST_WINDOW,
      ST_ERASE,
      ST_SUSP_WAIT,
      ST_SUSP,
      ST_PROG,
      ST_BULK,
      ST_ABORT
   } fesr_state_e;
endpackage

/* include/fesr_tmr_if.sv */
// Load/done link between the controller and its shared down-counter
`timescale 1ns/1ns
interface fesr_tmr_if;
   logic load;
   logic [fesr_pkg::TMR_W-1:0] count;
   logic done;
   modport ctrl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

/* src/fesr_timer.sv */
// Shared down-counter that times the window, suspend latency and abort recovery
`timescale 1ns/1ns
module fesr_timer
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Controller side
   fesr_tmr_if.tmr tmr
);
   logic [fesr_pkg::TMR_W-1:0] cnt;

   // ==========================================
   // Count down to zero; a load restarts it
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         cnt <= '0;
      else if (tmr.load)
         cnt <= tmr.count;
      else if (cnt != '0)
         cnt <= cnt - 1'b1;
   end

   // One-cycle pulse on the last count; a reload masks it
   assign tmr.done = (cnt == fesr_pkg::TMR_W'(1)) & ~tmr.load;
endmodule

/* src/fesr_ctrl.sv */
// Flash erase suspend/resume, reset-flash, sector protection and reset-pin abort
// Functional notes
// - B0h even address with select suspends erase
// - Suspend outside erase is ignored, stays read
// - Suspend inside window also ends the window
// - Toggle stops 0.1 to 15 us after suspend
// - Suspended erase falls back to read mode
// - Reads of suspended sectors flagged invalid
// - Reads of other sectors stay valid
// - Suspended state refuses program, allows resume/reset
// - Reset while suspended abandons the erase
// - 30h even address with select resumes erase
// - Commands to protected sectors silently ignored
// - Reads of protected sectors behave normally
// - Protection bits readable, never writable here
// - Reset-flash single write, unlock writes optional
// - Reset-flash read mode now, 25 us after error
// - Reset-flash ignored during program or bulk erase
// - Reset-flash aborts sector erase within 25 us
// - Reset pin aborts, read within 25 us
// - Toggle bit flips per read while busy; held during abort recovery here
// - Other command in window aborts to read
`timescale 1ns/1ns
module fesr_ctrl
#(
   parameter int ERASE_WIN_CYC = fesr_pkg::ERASE_WIN_CYC,
   parameter logic [7:0] RESET_CODE = fesr_pkg::CMD_RESET_DFLT
)
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Hardware reset pin, asynchronous
   input wire logic hw_rst_pin_n_in,
   // MCU bus cycle
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [fesr_pkg::ADDR_W-1:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic [fesr_pkg::PRI_N-1:0] primary_sector_selects_in,
   input wire logic [fesr_pkg::SEC2_N-1:0] secondary_sector_selects_in,
   // Decoded long commands
   input wire logic erase_req_in,
   input wire logic prog_req_in,
   input wire logic bulk_req_in,
   // Embedded algorithm engine
   input wire logic eng_done_in,
   input wire logic eng_error_in,
   // Nonvolatile protection bits
   input wire logic [fesr_pkg::SEC_N-1:0] prot_bits_in,
   // Engine control
   output logic erase_go_out,
   output logic prog_go_out,
   output logic bulk_go_out,
   output logic abort_out,
   output logic [fesr_pkg::SEC_N-1:0] erase_sectors_out,
   // Status
   output logic read_mode_out,
   output logic suspended_out,
   output logic window_out,
   output logic toggle_status_bit_out,
   output logic error_status_bit_out,
   output logic read_invalid_out,
   output logic [fesr_pkg::SEC_N-1:0] prot_bits_out
);
   fesr_pkg::fesr_state_e state, next_state;
   logic [fesr_pkg::SEC_N-1:0] sectors, next_sectors;
   logic pin_s1, pin_s2;
   logic tgl, err, abort_pulse, rd_bad;
   logic [fesr_pkg::SEC_N-1:0] prot;
   logic [fesr_pkg::TMR_W-1:0] abort_len; // Recovery length, kept only for the bound check

   fesr_tmr_if tif ();

   // ==========================================
   // Shared timer
   fesr_timer u_timer
   (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .tmr (tif)
   );

   // ==========================================
   // Reset pin synchroniser, idles released
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end
      else
      begin
         pin_s1 <= hw_rst_pin_n_in;
         pin_s2 <= pin_s1;
      end
   end

   // ==========================================
   // Command decode
   wire hw_rst = ~pin_s2;
   wire [fesr_pkg::SEC_N-1:0] sel = {secondary_sector_selects_in, primary_sector_selects_in};
   wire sel_any = |sel;
   wire even_wr = wr_in & sel_any & ~addr_in[0];
   wire is_susp = even_wr & (data_in == fesr_pkg::CMD_SUSPEND);
   wire is_res = even_wr & (data_in == fesr_pkg::CMD_RESUME);
   wire is_rst = wr_in & sel_any & (data_in == RESET_CODE);
   // Unlock cycles are neutral so an optional unlock never aborts
   wire unl1 = (addr_in == fesr_pkg::UNLOCK1_ADDR) & (data_in == fesr_pkg::UNLOCK1_DATA);
   wire unl2 = (addr_in == fesr_pkg::UNLOCK2_ADDR) & (data_in == fesr_pkg::UNLOCK2_DATA);
   wire is_unlock = wr_in & (unl1 | unl2);
   wire is_other = wr_in & sel_any & ~is_susp & ~is_res & ~is_unlock;
   wire hit_prot = |(sel & prot);
   wire prog_ok = prog_req_in & ~hit_prot;
   wire erase_ok = erase_req_in & ~hit_prot;
   wire busy = (state != fesr_pkg::ST_READ);
   wire tgl_live = (state == fesr_pkg::ST_WINDOW) | (state == fesr_pkg::ST_ERASE) |
                   (state == fesr_pkg::ST_SUSP_WAIT) | (state == fesr_pkg::ST_PROG) |
                   (state == fesr_pkg::ST_BULK);
   wire rst_taken = ~hw_rst & is_rst & ((state == fesr_pkg::ST_READ) |
                    (state == fesr_pkg::ST_ERASE) | (state == fesr_pkg::ST_SUSP) |
                    (state == fesr_pkg::ST_WINDOW));

   // ==========================================
   // Next state; reset pin wins over every command
   always_comb
   begin
      next_state = state;
      next_sectors = sectors;
      abort_pulse = 1'b0;
      tif.load = 1'b0;
      tif.count = '0;
      if (hw_rst)
      begin
         next_sectors = '0;
         abort_pulse = busy;
         if (busy)
         begin
            // Held pin keeps reloading, recovery counts from release
            next_state = fesr_pkg::ST_ABORT;
            tif.load = 1'b1;
            tif.count = fesr_pkg::TMR_W'(fesr_pkg::ABORT_CYC - 1);
         end
         else
            next_state = fesr_pkg::ST_READ;
      end
      else
      begin
         case (state)
            fesr_pkg::ST_READ:
            begin
               // Suspend and resume fall through here as plain reads
               if (prog_ok)
                  next_state = fesr_pkg::ST_PROG;
               else if (bulk_req_in)
               begin
                  next_state = fesr_pkg::ST_BULK;
                  next_sectors = ~prot;
               end
               else if (erase_ok)
               begin
                  next_state = fesr_pkg::ST_WINDOW;
                  next_sectors = sel;
                  tif.load = 1'b1;
                  tif.count = fesr_pkg::TMR_W'(ERASE_WIN_CYC - 1);
               end
               else if (is_rst && err)
               begin
                  // Failed algorithm needs recovery time
                  next_state = fesr_pkg::ST_ABORT;
                  tif.load = 1'b1;
                  tif.count = fesr_pkg::TMR_W'(fesr_pkg::ABORT_CYC - 1);
               end
            end
            fesr_pkg::ST_WINDOW:
            begin
               if (is_susp)
               begin
                  next_state = fesr_pkg::ST_SUSP_WAIT;
                  tif.load = 1'b1;
                  tif.count = fesr_pkg::TMR_W'(fesr_pkg::SUSP_CYC - 1);
               end
               else if (is_res)
               begin
                  // Extra sector code restarts the window
                  if (!hit_prot)
                  begin
                     next_sectors = sectors | sel;
                     tif.load = 1'b1;
                     tif.count = fesr_pkg::TMR_W'(ERASE_WIN_CYC - 1);
                  end
               end
               else if (is_other)
               begin
                  next_state = fesr_pkg::ST_READ;
                  next_sectors = '0;
                  abort_pulse = 1'b1;
               end
               else if (tif.done)
                  next_state = fesr_pkg::ST_ERASE;
            end
            fesr_pkg::ST_ERASE:
            begin
               if (is_susp)
               begin
                  next_state = fesr_pkg::ST_SUSP_WAIT;
                  tif.load = 1'b1;
                  tif.count = fesr_pkg::TMR_W'(fesr_pkg::SUSP_CYC - 1);
               end
               else if (is_rst)
               begin
                  next_state = fesr_pkg::ST_ABORT;
                  next_sectors = '0;
                  abort_pulse = 1'b1;
                  tif.load = 1'b1;
                  tif.count = fesr_pkg::TMR_W'(fesr_pkg::ABORT_CYC - 1);
               end
               else if (eng_done_in)
               begin
                  next_state = fesr_pkg::ST_READ;
                  next_sectors = '0;
               end
            end
            fesr_pkg::ST_SUSP_WAIT:
            begin
               if (tif.done)
                  next_state = fesr_pkg::ST_SUSP;
            end
            fesr_pkg::ST_SUSP:
            begin
               // Program and erase requests are simply not looked at
               if (is_res)
                  next_state = fesr_pkg::ST_ERASE;
               else if (is_rst)
               begin
                  next_state = fesr_pkg::ST_READ;
                  next_sectors = '0;
                  abort_pulse = 1'b1;
               end
            end
            fesr_pkg::ST_PROG, fesr_pkg::ST_BULK:
            begin
               // Reset-flash is ignored until the engine finishes
               if (eng_done_in)
               begin
                  next_state = fesr_pkg::ST_READ;
                  next_sectors = '0;
               end
            end
            fesr_pkg::ST_ABORT:
            begin
               if (tif.done)
                  next_state = fesr_pkg::ST_READ;
            end
            default:
               next_state = fesr_pkg::ST_READ;
         endcase
      end
   end

   // ==========================================
   // State and sector record
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         state <= fesr_pkg::ST_READ;
         sectors <= '0;
      end
      else
      begin
         state <= next_state;
         sectors <= next_sectors;
      end
   end

   // ==========================================
   // Status flops; error set wins over its clear
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         tgl <= 1'b0;
         err <= 1'b0;
         rd_bad <= 1'b0;
         prot <= '0;
         abort_len <= '0;
      end
      else
      begin
         if (rd_in && sel_any && tgl_live)
            tgl <= ~tgl;
         if (eng_error_in)
            err <= 1'b1;
         else if (rst_taken)
            err <= 1'b0;
         rd_bad <= rd_in & (state == fesr_pkg::ST_SUSP) & (|(sel & sectors));
         prot <= prot_bits_in;
         abort_len <= (hw_rst || state != fesr_pkg::ST_ABORT) ? '0 : abort_len + 1'b1;
      end
   end

   // ==========================================
   // Output decode
   assign erase_go_out = (state == fesr_pkg::ST_ERASE);
   assign prog_go_out = (state == fesr_pkg::ST_PROG);
   assign bulk_go_out = (state == fesr_pkg::ST_BULK);
   assign abort_out = abort_pulse;
   assign erase_sectors_out = sectors;
   assign read_mode_out = (state == fesr_pkg::ST_READ) | (state == fesr_pkg::ST_SUSP);
   assign suspended_out = (state == fesr_pkg::ST_SUSP);
   assign window_out = (state == fesr_pkg::ST_WINDOW);
   assign toggle_status_bit_out = tgl;
   assign error_status_bit_out = err;
   assign read_invalid_out = rd_bad;
   assign prot_bits_out = prot;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_susp_taken;
      !hw_rst && (state == fesr_pkg::ST_ERASE) && is_susp;
   endsequence
   sequence s_erase_reset;
      !hw_rst && (state == fesr_pkg::ST_ERASE) && is_rst;
   endsequence
   chk_susp_enter: assert property (s_susp_taken |=> state == fesr_pkg::ST_SUSP_WAIT)
      else $error("suspend not taken during erase");
   chk_susp_idle: assert property (!hw_rst && !busy && is_susp && !erase_ok && !prog_ok && !bulk_req_in
      |=> read_mode_out && !busy)
      else $error("suspend acted outside erase");
   chk_window_end: assert property (!hw_rst && window_out && is_susp |=> !window_out && !suspended_out)
      else $error("window not ended by suspend");
   chk_toggle_stop: assert property (s_susp_taken |=> !suspended_out ##9 suspended_out)
      else $error("suspend latency wrong");
   chk_invalid_read: assert property (suspended_out && rd_in && |(sel & sectors) |=> read_invalid_out)
      else $error("suspended sector read not flagged");
   chk_valid_read: assert property (rd_in && !(|(sel & sectors)) |=> !read_invalid_out)
      else $error("other sector read flagged");
   chk_prog_refused: assert property (suspended_out && prog_req_in && !hw_rst |=> !prog_go_out)
      else $error("program taken while suspended");
   chk_susp_reset: assert property (!hw_rst && suspended_out && is_rst
      |=> read_mode_out && !suspended_out && sectors == '0)
      else $error("reset did not abandon erase");
   chk_resume_go: assert property (!hw_rst && suspended_out && is_res |=> erase_go_out)
      else $error("resume did not restart erase");
   chk_prot_ignore: assert property (!hw_rst && !busy && prog_req_in && hit_prot |=> !prog_go_out)
      else $error("protected sector programmed");
   chk_reset_ignored: assert property (!hw_rst && prog_go_out && is_rst && !eng_done_in |=> prog_go_out)
      else $error("reset-flash stopped a program");
   chk_erase_abort: assert property (s_erase_reset |=> state == fesr_pkg::ST_ABORT && !erase_go_out)
      else $error("erase abort not started");
   chk_abort_bound: assert property (abort_len < fesr_pkg::TMR_W'(fesr_pkg::ABORT_CYC))
      else $error("abort recovery too long");
   chk_pin_abort: assert property (hw_rst |=> !erase_go_out && !prog_go_out && !bulk_go_out)
      else $error("reset pin did not abort");
   chk_toggle_busy: assert property (rd_in && sel_any && tgl_live && !hw_rst
      |=> toggle_status_bit_out != $past(toggle_status_bit_out))
      else $error("toggle bit did not flip");
   chk_window_abort: assert property (!hw_rst && window_out && is_other |=> state == fesr_pkg::ST_READ)
      else $error("window not aborted by other command");
endmodule

/* sim/fesr_mcu_model.sv */
// MCU-side bus master model: command writes, status reads and the reset pin
`timescale 1ns/1ns
module fesr_mcu_model
(
   // Clock
   input wire logic ref_clk_in,
   // Bus towards the controller
   output logic wr_out,
   output logic rd_out,
   output logic [fesr_pkg::ADDR_W-1:0] addr_out,
   output logic [7:0] data_out,
   output logic [fesr_pkg::SEC_N-1:0] sel_out,
   // Hardware reset pin, active low
   output logic hw_rst_pin_n_out
);
   // ==========================================
   // Idle bus at time zero
   initial
   begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 12'h0fff;
      data_out = 8'h5a;
      sel_out = '0;
      hw_rst_pin_n_out = 1'b1;
   end

   // ==========================================
   // Bus cycles; released lines show inverted data so stale values never match
   task bus_write(input logic [11:0] a, input logic [7:0] d, input logic [11:0] s);
      @(posedge ref_clk_in);
      wr_out <= 1'b1;
      addr_out <= a;
      data_out <= d;
      sel_out <= s;
      @(posedge ref_clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      data_out <= ~d;
      sel_out <= '0;
   endtask

   // Status read, caller picks the erased sector when polling the toggle bit
   task bus_read(input logic [11:0] s);
      @(posedge ref_clk_in);
      rd_out <= 1'b1;
      sel_out <= s;
      @(posedge ref_clk_in);
      rd_out <= 1'b0;
      sel_out <= '0;
   endtask

   // Selects for a request decoded elsewhere, applied in the caller's time step
   task select(input logic [11:0] s);
      sel_out <= s;
   endtask

   // Pin pulse, held low for n clocks; abort recovery only starts counting at release
   task pin_reset(input int n);
      @(posedge ref_clk_in);
      hw_rst_pin_n_out <= 1'b0;
      repeat (n) @(posedge ref_clk_in);
      hw_rst_pin_n_out <= 1'b1;
   endtask
endmodule

/* sim/fesr_ctrl_bench.sv */
// Self-checking bench for the erase suspend/reset controller
`timescale 1ns/1ns
module fesr_ctrl_bench;
   logic ref_clk_in, sys_rst_in, wr, rd, hw_n, erase_req, prog_req, bulk_req, done, err;
   logic [11:0] addr, sel, prot;
   logic [7:0] data;
   logic erase_go_out, prog_go_out, bulk_go_out, abort_out, read_mode_out, suspended_out;
   logic window_out, toggle_status_bit_out, error_status_bit_out, read_invalid_out;
   logic [11:0] erase_sectors_out, prot_bits_out;
   int fails, cmp_count, cyc, aborts;
   logic t;

   // ==========================================
   // Design and MCU model, short erase window for simulation
   fesr_ctrl #(.ERASE_WIN_CYC(20)) i_fesr_ctrl (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .hw_rst_pin_n_in(hw_n), .wr_in(wr), .rd_in(rd), .addr_in(addr), .data_in(data),
      .primary_sector_selects_in(sel[7:0]), .secondary_sector_selects_in(sel[11:8]),
      .erase_req_in(erase_req), .prog_req_in(prog_req), .bulk_req_in(bulk_req), .eng_done_in(done),
      .eng_error_in(err), .prot_bits_in(prot), .erase_go_out(erase_go_out), .prog_go_out(prog_go_out),
      .bulk_go_out(bulk_go_out), .abort_out(abort_out), .erase_sectors_out(erase_sectors_out),
      .read_mode_out(read_mode_out), .suspended_out(suspended_out), .window_out(window_out),
      .toggle_status_bit_out(toggle_status_bit_out), .error_status_bit_out(error_status_bit_out),
      .read_invalid_out(read_invalid_out), .prot_bits_out(prot_bits_out));
   fesr_mcu_model i_fesr_mcu_model (.ref_clk_in(ref_clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
      .data_out(data), .sel_out(sel), .hw_rst_pin_n_out(hw_n));

   // ==========================================
   // Clock and hang guard, ceiling well above the three long aborts
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (abort_out === 1'b1)
         aborts++; // Abort pulses, sampled where they are settled
      if (cyc == 40000)
      begin
         fails++;
         close_out();
      end
   end

   // ==========================================
   // Helpers
   task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task wr_cmd(input logic [11:0] a, input logic [7:0] d, input logic [11:0] s);
      i_fesr_mcu_model.bus_write(a, d, s);
   endtask
   task rd_at(input logic [11:0] s);
      i_fesr_mcu_model.bus_read(s);
   endtask
   // Bounded wait on read mode (0) or suspended (1)
   task wait_hi(input int w, input int lim);
      int n;
      n = 0;
      while (((w == 0) ? read_mode_out : suspended_out) !== 1'b1 && n < lim)
      begin
         tick(1);
         n++;
      end
      chk("wait_flag", 12'h0001, {11'h000, (w == 0) ? read_mode_out : suspended_out});
   endtask
   // Request pulse from the command decoder: 0 erase, 1 program, 2 bulk
   task request(input int k, input logic [11:0] s);
      @(posedge ref_clk_in);
      i_fesr_mcu_model.select(s);
      erase_req <= (k == 0);
      prog_req <= (k == 1);
      bulk_req <= (k == 2);
      @(posedge ref_clk_in);
      i_fesr_mcu_model.select('0);
      {erase_req, prog_req, bulk_req} <= 3'b000;
   endtask
   task engine(input logic e);
      @(posedge ref_clk_in);
      done <= 1'b1;
      err <= e;
      @(posedge ref_clk_in);
      done <= 1'b0;
      err <= 1'b0;
   endtask
   task run_erase(input logic [11:0] s);
      request(0, s);
      tick(25);
      chk("erase_go", 12'h0001, erase_go_out);
   endtask

   // ==========================================
   // Scenarios
   task s_idle;
      chk("read_mode", 12'h0001, read_mode_out);
      chk("prot_copy", 12'h0800, prot_bits_out);
      wr_cmd(12'h000, 8'hb0, 12'h001);
      tick(15);
      chk("idle_susp", 12'h0000, suspended_out);
      chk("idle_read", 12'h0001, read_mode_out);
   endtask
   task s_window_suspend;
      request(0, 12'h002);
      tick(1);
      chk("window", 12'h0001, window_out);
      wr_cmd(12'h020, 8'h30, 12'h008);
      tick(1);
      chk("sectors", 12'h000a, erase_sectors_out);
      wr_cmd(12'h040, 8'hb0, 12'h002);
      tick(1);
      chk("window_end", 12'h0000, window_out);
      tick(3);
      chk("susp_early", 12'h0000, suspended_out);
      wait_hi(1, 1500);
      chk("susp_read", 12'h0001, read_mode_out);
      wr_cmd(12'h123, 8'hf0, 12'h001);
      tick(2);
      wait_hi(0, 2600);
      chk("abandon", 12'h0000, {erase_sectors_out[11:1], suspended_out});
   endtask
   task s_erase_suspend;
      run_erase(12'h004);
      t = toggle_status_bit_out;
      rd_at(12'h004);
      tick(1);
      chk("toggle_busy", {11'h000, ~t}, toggle_status_bit_out);
      wr_cmd(12'h011, 8'hb0, 12'h004);
      tick(15);
      chk("odd_addr", 12'h0001, erase_go_out);
      wr_cmd(12'h010, 8'hb0, 12'h004);
      tick(1);
      chk("erase_halt", 12'h0000, erase_go_out);
      wait_hi(1, 1500);
      t = toggle_status_bit_out;
      // Invalid flag stands one cycle only, so look just after the read
      rd_at(12'h004);
      #1;
      chk("toggle_stop", {11'h000, t}, toggle_status_bit_out);
      chk("rd_invalid", 12'h0001, read_invalid_out);
      rd_at(12'h010);
      #1;
      chk("rd_valid", 12'h0000, read_invalid_out);
      request(1, 12'h010);
      tick(2);
      chk("prog_refused", 12'h0001, {prog_go_out, suspended_out});
      wr_cmd(12'h010, 8'h30, 12'h004);
      tick(1);
      chk("resumed", 12'h0002, {erase_go_out, suspended_out});
      engine(1'b0);
      tick(1);
      chk("erase_end", 12'h0001, {erase_sectors_out[11:1], read_mode_out});
   endtask
   task s_protect;
      request(0, 12'h800);
      tick(2);
      chk("prot_erase", 12'h0001, {window_out, read_mode_out});
      request(1, 12'h800);
      tick(2);
      chk("prot_prog", 12'h0000, prog_go_out);
      rd_at(12'h800);
      #1;
      chk("prot_read", 12'h0000, read_invalid_out);
   endtask
   task s_window_abort;
      request(0, 12'h001);
      tick(1);
      aborts = 0;
      wr_cmd(12'h002, 8'h12, 12'h001);
      tick(1);
      chk("win_sectors", 12'h0000, erase_sectors_out);
      chk("win_abort", 12'h0001, {10'h000, window_out, read_mode_out});
      chk("win_abort_pulse", 12'h0001, aborts[11:0]);
   endtask
   task s_busy_reset;
      request(1, 12'h001);
      wr_cmd(12'h000, 8'hf0, 12'h001);
      tick(3);
      chk("prog_keep", 12'h0001, prog_go_out);
      engine(1'b0);
      request(2, 12'h001);
      wr_cmd(12'h000, 8'hf0, 12'h001);
      tick(3);
      chk("bulk_keep", 12'h0001, bulk_go_out);
      engine(1'b0);
      tick(1);
      chk("bulk_end", 12'h0001, read_mode_out);
   endtask
   task s_erase_reset;
      run_erase(12'h002);
      aborts = 0;
      wr_cmd(12'haaa, 8'haa, 12'h002);
      wr_cmd(12'h554, 8'h55, 12'h002);
      wr_cmd(12'h100, 8'hf0, 12'h002);
      tick(1);
      chk("erase_abort", 12'h0000, erase_go_out);
      chk("erase_abort_pulse", 12'h0001, aborts[11:0]);
      wait_hi(0, 2600);
   endtask
   task s_error;
      run_erase(12'h001);
      engine(1'b1);
      tick(1);
      chk("err_set", 12'h0001, error_status_bit_out);
      wr_cmd(12'h000, 8'hf0, 12'h001);
      tick(2);
      wait_hi(0, 2600);
      chk("err_clear", 12'h0000, error_status_bit_out);
   endtask
   task s_pin;
      run_erase(12'h001);
      i_fesr_mcu_model.pin_reset(2500);
      tick(4);
      chk("pin_abort", 12'h0000, erase_go_out);
      wait_hi(0, 2600);
   endtask

   // ==========================================
   // Verdict and run
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      {sys_rst_in, erase_req, prog_req, bulk_req, done, err} = 6'b100000;
      prot = 12'h800;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (20) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      tick(2);
      s_idle();
      s_window_suspend();
      s_erase_suspend();
      s_protect();
      s_window_abort();
      s_busy_reset();
      s_erase_reset();
      s_error();
      s_pin();
      close_out();
   end
endmodule
